// *** dsp_pkg.sv ***
// Shared types and constants for the DRAM low-power state block
package dsp_pkg;

   // ===========================================================
   // Low-power states
   typedef enum logic [2:0] {
      DSP_IDLE = 3'b000,
      DSP_APD  = 3'b001,
      DSP_PPD  = 3'b010,
      DSP_SR   = 3'b011,
      DSP_EXIT = 3'b100
   } dsp_state_t;

   // ===========================================================
   // Pin groups
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } dsp_cmd_t;

   typedef struct packed {
      logic dll_en;
      logic dll_reset;
      logic int_clk_en;
      logic rx_en;
      logic nondll_ready;
      logic dll_ready;
      logic self_refresh;
   } dsp_stat_t;

   localparam dsp_stat_t STAT_RST = '{dll_en: 1'b0, dll_reset: 1'b0, int_clk_en: 1'b1, rx_en: 1'b1,
                                      nondll_ready: 1'b1, dll_ready: 1'b1, self_refresh: 1'b0};

   // ===========================================================
   // Link timing in link clock cycles
   localparam int             CW         = 10;
   localparam logic [CW-1:0]  CNT_ZERO   = 10'h000;
   localparam logic [CW-1:0]  CNT_ONE    = 10'h001;
   localparam logic [CW-1:0]  TXS_NCK    = 10'h010;
   localparam logic [CW-1:0]  TXSDLL_NCK = 10'h200;
   localparam logic [CW-1:0]  TXP_NCK    = 10'h004;
   localparam logic [CW-1:0]  TXPDLL_NCK = 10'h00a;
   localparam logic [CW-1:0]  TCPDED_NCK = 10'h001;

   // ===========================================================
   // Internal refresh timer on the core clock
   localparam int             CLK_PERIOD_PS = 10000;
   localparam int             TREFI_NS      = 7800;
   localparam int             TREFI_CYC     = (TREFI_NS * 1000) / CLK_PERIOD_PS;
   localparam int             RW            = 12;

endpackage

// *** dsp_sync.sv ***
// Two-stage level synchroniser
`timescale 1ns/1ps
module dsp_sync (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic d,
   output logic      q
);
   logic meta;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta <= 1'b0;
         q    <= 1'b0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// *** dsp_lowpower.sv ***
// DRAM self-refresh and power-down state handling
`timescale 1ns/1ps
module dsp_lowpower #(
   parameter logic [dsp_pkg::CW-1:0] TXS    = dsp_pkg::TXS_NCK,
   parameter logic [dsp_pkg::CW-1:0] TXSDLL = dsp_pkg::TXSDLL_NCK,
   parameter logic [dsp_pkg::CW-1:0] TXP    = dsp_pkg::TXP_NCK,
   parameter logic [dsp_pkg::CW-1:0] TXPDLL = dsp_pkg::TXPDLL_NCK,
   parameter logic [dsp_pkg::CW-1:0] TCPDED = dsp_pkg::TCPDED_NCK
) (
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire logic               ck,
   input  wire logic               mem_reset_n,
   input  wire logic               cke,
   input  wire dsp_pkg::dsp_cmd_t  cmd,
   input  wire logic               banks_open,
   input  wire logic               ops_busy,
   input  wire logic               mr0_pd_fast,
   input  wire logic               mr1_dll_disable,
   output dsp_pkg::dsp_stat_t      status,
   output dsp_pkg::dsp_state_t     lp_state,
   output logic                    int_refresh
);
   // ===========================================================
   // Command decode on the link clock
   logic                      is_nop;
   logic                      is_ref_code;
   logic                      self_refresh_entry;
   logic                      self_refresh_exit;
   logic                      pd_entry;
   logic                      pd_exit;
   dsp_pkg::dsp_state_t       next_state;
   logic [dsp_pkg::CW-1:0]    xs_cnt;
   logic [dsp_pkg::CW-1:0]    dll_cnt;
   logic [dsp_pkg::CW-1:0]    cpded_cnt;
   logic [dsp_pkg::CW-1:0]    next_xs_cnt;
   logic [dsp_pkg::CW-1:0]    next_dll_cnt;
   logic [dsp_pkg::CW-1:0]    next_cpded_cnt;
   logic                      next_in_pd;

   assign is_nop      = cmd.cs_n | (cmd.ras_n & cmd.cas_n & cmd.we_n);
   assign is_ref_code = ~cmd.cs_n & ~cmd.ras_n & ~cmd.cas_n & cmd.we_n;
   assign self_refresh_entry = ~cke & is_ref_code;
   assign self_refresh_exit  = cke & is_nop;
   assign pd_entry    = ~cke & is_nop;
   assign pd_exit     = cke & is_nop;

   // ===========================================================
   // Low-power state machine
   always_comb begin
      next_state = lp_state;
      unique case (lp_state)
         dsp_pkg::DSP_IDLE: begin
            if (self_refresh_entry) begin
               next_state = dsp_pkg::DSP_SR;
            end else if (pd_entry) begin
               next_state = banks_open ? dsp_pkg::DSP_APD : dsp_pkg::DSP_PPD;
            end
         end
         dsp_pkg::DSP_APD, dsp_pkg::DSP_PPD: begin
            if (pd_exit) begin
               next_state = dsp_pkg::DSP_EXIT;
            end else if (!ops_busy) begin
               next_state = banks_open ? dsp_pkg::DSP_APD : dsp_pkg::DSP_PPD;
            end
         end
         dsp_pkg::DSP_SR: begin
            // CKE high together with a NOP or deselect on the other pins ends self-refresh
            if (self_refresh_exit) begin
               next_state = dsp_pkg::DSP_EXIT;
            end
         end
         dsp_pkg::DSP_EXIT: begin
            if (dll_cnt == dsp_pkg::CNT_ZERO) begin
               next_state = dsp_pkg::DSP_IDLE;
            end else if (self_refresh_entry && xs_cnt == dsp_pkg::CNT_ZERO) begin
               next_state = dsp_pkg::DSP_SR;
            end
         end
         default: next_state = dsp_pkg::DSP_IDLE;
      endcase
   end

   // ===========================================================
   // Exit and receiver-off counters
   always_comb begin
      next_xs_cnt    = (xs_cnt != dsp_pkg::CNT_ZERO) ? xs_cnt - dsp_pkg::CNT_ONE : xs_cnt;
      next_dll_cnt   = (dll_cnt != dsp_pkg::CNT_ZERO) ? dll_cnt - dsp_pkg::CNT_ONE : dll_cnt;
      next_cpded_cnt = (cpded_cnt != dsp_pkg::CNT_ZERO) ? cpded_cnt - dsp_pkg::CNT_ONE : cpded_cnt;
      next_in_pd     = (next_state == dsp_pkg::DSP_APD) || (next_state == dsp_pkg::DSP_PPD);
      if (lp_state != dsp_pkg::DSP_EXIT && next_state == dsp_pkg::DSP_EXIT) begin
         if (lp_state == dsp_pkg::DSP_SR) begin
            next_xs_cnt  = TXS;
            next_dll_cnt = TXSDLL;
         end else if (lp_state == dsp_pkg::DSP_PPD && !mr0_pd_fast) begin
            next_xs_cnt  = TXP;
            next_dll_cnt = TXPDLL;
         end else begin
            next_xs_cnt  = TXP;
            next_dll_cnt = TXP;
         end
      end else if (next_state == dsp_pkg::DSP_SR) begin
         next_xs_cnt  = dsp_pkg::CNT_ZERO;
         next_dll_cnt = dsp_pkg::CNT_ZERO;
      end
      if (lp_state == dsp_pkg::DSP_IDLE && next_in_pd) begin
         next_cpded_cnt = TCPDED;
      end
   end

   // Reset pin low drops any power-down straight back to idle
   always_ff @(posedge ck) begin
      if (!mem_reset_n) begin
         lp_state  <= dsp_pkg::DSP_IDLE;
         xs_cnt    <= dsp_pkg::CNT_ZERO;
         dll_cnt   <= dsp_pkg::CNT_ZERO;
         cpded_cnt <= dsp_pkg::CNT_ZERO;
      end else begin
         lp_state  <= next_state;
         xs_cnt    <= next_xs_cnt;
         dll_cnt   <= next_dll_cnt;
         cpded_cnt <= next_cpded_cnt;
      end
   end

   // ===========================================================
   // Status flops
   always_ff @(posedge ck) begin
      if (!mem_reset_n) begin
         status <= dsp_pkg::STAT_RST;
      end else begin
         status.dll_en <= !mr1_dll_disable && next_state != dsp_pkg::DSP_SR
                          && !(next_state == dsp_pkg::DSP_PPD && !mr0_pd_fast);
         status.dll_reset    <= lp_state == dsp_pkg::DSP_SR && next_state == dsp_pkg::DSP_EXIT
                                && !mr1_dll_disable;
         status.int_clk_en   <= next_state != dsp_pkg::DSP_SR;
         status.rx_en        <= !(next_in_pd && next_cpded_cnt == dsp_pkg::CNT_ZERO);
         status.nondll_ready <= next_state == dsp_pkg::DSP_IDLE
                                || (next_state == dsp_pkg::DSP_EXIT && next_xs_cnt == dsp_pkg::CNT_ZERO);
         status.dll_ready    <= next_state == dsp_pkg::DSP_IDLE;
         status.self_refresh <= next_state == dsp_pkg::DSP_SR;
      end
   end

   // ===========================================================
   // Internal refresh timer on the core clock
   // The link clock may stop in self-refresh, so the timer runs on clk
   logic                  sr_sync;
   logic                  sr_prev;
   logic [dsp_pkg::RW-1:0] refi_cnt;

   dsp_sync u_sr_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (status.self_refresh),
      .q    (sr_sync)
   );

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sr_prev     <= 1'b0;
         refi_cnt    <= '0;
         int_refresh <= 1'b0;
      end else begin
         sr_prev     <= sr_sync;
         int_refresh <= 1'b0;
         if (sr_sync && !sr_prev) begin
            int_refresh <= 1'b1;
            refi_cnt    <= dsp_pkg::RW'(dsp_pkg::TREFI_CYC - 1);
         end else if (sr_sync) begin
            if (refi_cnt == '0) begin
               int_refresh <= 1'b1;
               refi_cnt    <= dsp_pkg::RW'(dsp_pkg::TREFI_CYC - 1);
            end else begin
               refi_cnt <= refi_cnt - 1'b1;
            end
         end
      end
   end

   // ===========================================================
   // Checks
   sequence s_idle_sre;
      lp_state == dsp_pkg::DSP_IDLE && self_refresh_entry;
   endsequence
   sequence s_sr_exit;
      lp_state == dsp_pkg::DSP_SR && self_refresh_exit;
   endsequence

   AST_SRE_DECODE: assert property (@(posedge ck) disable iff (!mem_reset_n)
      s_idle_sre |=> lp_state == dsp_pkg::DSP_SR && status.self_refresh)
      else $error("Self-refresh entry not taken");
   AST_REF_NOT_SR: assert property (@(posedge ck) disable iff (!mem_reset_n)
      lp_state == dsp_pkg::DSP_IDLE && cke && is_ref_code |=> lp_state == dsp_pkg::DSP_IDLE)
      else $error("Refresh with CKE high left idle");
   AST_SR_DLL_OFF: assert property (@(posedge ck) disable iff (!mem_reset_n)
      s_idle_sre |=> !status.dll_en until lp_state != dsp_pkg::DSP_SR)
      else $error("DLL on in self-refresh");
   AST_SR_EXIT_RESET: assert property (@(posedge ck) disable iff (!mem_reset_n)
      s_sr_exit and !mr1_dll_disable |=> status.dll_reset ##1 !status.dll_reset)
      else $error("DLL reset pulse missing on exit");
   AST_SR_CLK_GATED: assert property (@(posedge ck) disable iff (!mem_reset_n)
      lp_state == dsp_pkg::DSP_SR |-> !status.int_clk_en && !status.dll_ready)
      else $error("Internal clock running in self-refresh");
   AST_PD_ENTRY: assert property (@(posedge ck) disable iff (!mem_reset_n)
      lp_state == dsp_pkg::DSP_IDLE && pd_entry |=>
      lp_state == ($past(banks_open) ? dsp_pkg::DSP_APD : dsp_pkg::DSP_PPD))
      else $error("Power-down entry wrong");
   AST_RX_OFF: assert property (@(posedge ck) disable iff (!mem_reset_n)
      (lp_state == dsp_pkg::DSP_APD || lp_state == dsp_pkg::DSP_PPD) && cpded_cnt == dsp_pkg::CNT_ZERO
      |-> !status.rx_en)
      else $error("Receivers on after tCPDED");
   AST_PPD_SLOW: assert property (@(posedge ck) disable iff (!mem_reset_n)
      lp_state == dsp_pkg::DSP_PPD && !mr0_pd_fast && $stable(mr0_pd_fast) |-> !status.dll_en)
      else $error("DLL on in slow precharge power-down");
   AST_APD_DLL_ON: assert property (@(posedge ck) disable iff (!mem_reset_n)
      lp_state == dsp_pkg::DSP_APD && !mr1_dll_disable && $stable(mr1_dll_disable) |-> status.dll_en)
      else $error("DLL off in active power-down");
   AST_EXIT_WAIT: assert property (@(posedge ck) disable iff (!mem_reset_n)
      s_sr_exit |=> !status.dll_ready && !status.nondll_ready)
      else $error("Exit wait skipped");
   AST_RESET_PD: assert property (@(posedge ck)
      !mem_reset_n |=> lp_state == dsp_pkg::DSP_IDLE)
      else $error("Reset did not leave power-down");
   AST_FIRST_REF: assert property (@(posedge clk) disable iff (!rstn)
      $rose(sr_sync) |=> int_refresh)
      else $error("No internal refresh on self-refresh entry");
   AST_NO_REF_OUT: assert property (@(posedge clk) disable iff (!rstn)
      !sr_sync && !sr_prev |=> !int_refresh)
      else $error("Internal refresh outside self-refresh");
   AST_PD_BUSY_HOLD: assert property (@(posedge ck) disable iff (!mem_reset_n)
      (lp_state == dsp_pkg::DSP_APD || lp_state == dsp_pkg::DSP_PPD) && !pd_exit && ops_busy
      |=> lp_state == $past(lp_state))
      else $error("Power-down flavour changed while busy");
   AST_SR_REENTRY: assert property (@(posedge ck) disable iff (!mem_reset_n)
      lp_state == dsp_pkg::DSP_EXIT && self_refresh_entry && xs_cnt == dsp_pkg::CNT_ZERO
      && dll_cnt != dsp_pkg::CNT_ZERO |=> lp_state == dsp_pkg::DSP_SR)
      else $error("Self-refresh re-entry refused after tXS");
endmodule

// *** dsp_ctrl_model.sv ***
// Behavioural memory controller driving the link clock, CKE, commands and reset pin
`timescale 1ns/1ps
module dsp_ctrl_model (
   output logic              ck,
   output logic              cke,
   output dsp_pkg::dsp_cmd_t cmd,
   output logic              mem_reset_n
);
   // ==========================================================
   // Link clock, free running so power-down always sees a stable clock
   initial begin
      ck = 1'b0;
      cke = 1'b1;
      cmd = 4'hf;
      mem_reset_n = 1'b0;
      #3.3;
      forever #7.5 ck = ~ck;
   end

   // ==========================================================
   // Pins change after a falling edge and hold until the next request,
   // so CKE stays low for the whole stay in self-refresh or power-down
   task automatic issue(input logic c, input dsp_pkg::dsp_cmd_t k, input int n);
      repeat (n) begin
         @(negedge ck);
         cke <= c;
         cmd <= k;
         @(posedge ck);
      end
      #1;
   endtask

   task automatic set_reset(input logic v, input int n);
      @(negedge ck);
      mem_reset_n <= v;
      repeat (n) @(posedge ck);
      #1;
   endtask
endmodule

// *** dsp_lowpower_tb.sv ***
// Self-checking testbench for the DRAM low-power state block
`timescale 1ns/1ps
module dsp_lowpower_tb;
   // ==========================================================
   // Signals
   typedef struct packed {
      logic              cke;
      dsp_pkg::dsp_cmd_t cmd;
      logic              bo;
      logic              fast;
      logic [3:0]        waits;
      logic [2:0]        st;
      logic              chk;
      logic              dll;
   } dsp_row_t;

   logic                clk             = 1'b0;
   logic                rstn            = 1'b0;
   logic                banks_open      = 1'b0;
   logic                ops_busy        = 1'b0;
   logic                mr0_pd_fast     = 1'b0;
   logic                mr1_dll_disable = 1'b0;
   logic                ck;
   logic                cke;
   logic                mem_reset_n;
   logic                int_refresh;
   dsp_pkg::dsp_cmd_t   cmd;
   dsp_pkg::dsp_stat_t  status;
   dsp_pkg::dsp_state_t lp_state;
   int                  fail_count      = 0;
   int                  num_checks      = 0;
   int                  n;

   // Each row is one command edge, plus extra edges repeating that command before the compare
   dsp_row_t rows [15] = '{
      '{1'b1, 4'h1, 1'b0, 1'b0, 4'h0, 3'h0, 1'b1, 1'b1}, '{1'b0, 4'h7, 1'b1, 1'b0, 4'h0, 3'h1, 1'b1, 1'b1},
      '{1'b1, 4'h7, 1'b1, 1'b0, 4'h0, 3'h4, 1'b0, 1'b0}, '{1'b1, 4'h7, 1'b0, 1'b0, 4'h8, 3'h0, 1'b0, 1'b0},
      '{1'b0, 4'hf, 1'b0, 1'b0, 4'h0, 3'h2, 1'b1, 1'b0}, '{1'b1, 4'hf, 1'b0, 1'b0, 4'h0, 3'h4, 1'b0, 1'b0},
      '{1'b1, 4'hf, 1'b0, 1'b0, 4'h8, 3'h0, 1'b1, 1'b1}, '{1'b0, 4'h7, 1'b0, 1'b1, 4'h0, 3'h2, 1'b1, 1'b1},
      '{1'b0, 4'h7, 1'b1, 1'b1, 4'h0, 3'h1, 1'b1, 1'b1}, '{1'b1, 4'h7, 1'b1, 1'b1, 4'h0, 3'h4, 1'b0, 1'b0},
      '{1'b1, 4'h7, 1'b0, 1'b0, 4'h8, 3'h0, 1'b0, 1'b0}, '{1'b0, 4'h1, 1'b0, 1'b0, 4'h0, 3'h3, 1'b1, 1'b0},
      '{1'b0, 4'h3, 1'b1, 1'b0, 4'h0, 3'h3, 1'b1, 1'b0}, '{1'b1, 4'h7, 1'b0, 1'b0, 4'h0, 3'h4, 1'b0, 1'b0},
      '{1'b1, 4'h7, 1'b0, 1'b0, 4'h8, 3'h0, 1'b1, 1'b1}};

   always #5 clk = ~clk;

   dsp_ctrl_model u_ctrl (.ck(ck), .cke(cke), .cmd(cmd), .mem_reset_n(mem_reset_n));

   // Short link timings keep the run brief
   dsp_lowpower #(.TXS(10'h003), .TXSDLL(10'h006), .TXP(10'h002), .TXPDLL(10'h004), .TCPDED(10'h001)) uut (
      .clk(clk), .rstn(rstn), .ck(ck), .mem_reset_n(mem_reset_n), .cke(cke), .cmd(cmd),
      .banks_open(banks_open), .ops_busy(ops_busy), .mr0_pd_fast(mr0_pd_fast),
      .mr1_dll_disable(mr1_dll_disable), .status(status), .lp_state(lp_state), .int_refresh(int_refresh));

   // ==========================================================
   // Checking and closing
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Whole sequence needs about 10 us; cut off well beyond that
   initial begin
      #100000;
      fail_count++;
      complete_run();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      u_ctrl.set_reset(1'b0, 2);
      check(8'(status), 8'(dsp_pkg::STAT_RST));
      check(8'(lp_state), 8'h00);
      u_ctrl.set_reset(1'b1, 1);
      for (int i = 0; i < 15; i++) begin
         @(negedge clk);
         banks_open = rows[i].bo;
         mr0_pd_fast = rows[i].fast;
         u_ctrl.issue(rows[i].cke, rows[i].cmd, 1 + int'(rows[i].waits));
         check(8'(lp_state), 8'(rows[i].st));
         if (rows[i].chk) check(8'(status.dll_en), 8'(rows[i].dll));
      end
      // Self-refresh: clock gated, refresh from the internal timer
      u_ctrl.issue(1'b0, 4'h1, 1);
      check(8'({status.self_refresh, status.int_clk_en}), 8'h02);
      n = 0;
      while (int_refresh !== 1'b1 && n < 12) begin
         @(negedge clk);
         n++;
      end
      check(8'(int_refresh), 8'h01);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (int_refresh !== 1'b1 && n < 800);
      check(8'(n >= dsp_pkg::TREFI_CYC - 1 && n <= dsp_pkg::TREFI_CYC + 1), 8'h01);
      // Exit: one-cycle DLL reset, then the two waits
      u_ctrl.issue(1'b1, 4'hf, 1);
      check(8'({status.dll_reset, status.nondll_ready, status.dll_ready}), 8'h04);
      u_ctrl.issue(1'b1, 4'hf, 1);
      check(8'(status.dll_reset), 8'h00);
      n = 1;
      while (status.nondll_ready !== 1'b1 && n < 20) begin
         u_ctrl.issue(1'b1, 4'hf, 1);
         n++;
      end
      check(8'(n), 8'h03);
      while (lp_state !== dsp_pkg::DSP_IDLE && n < 20) begin
         u_ctrl.issue(1'b1, 4'hf, 1);
         n++;
      end
      check(8'(n >= 6 && n <= 8 && status.dll_ready === 1'b1), 8'h01);
      // DLL off in MR1, then re-entry from the exit wait once tXS is over
      @(negedge clk);
      mr1_dll_disable = 1'b1;
      u_ctrl.issue(1'b0, 4'h1, 4);
      check(8'({status.self_refresh, status.dll_en}), 8'h02);
      u_ctrl.issue(1'b1, 4'hf, 1);
      check(8'({status.dll_reset, status.dll_en}), 8'h00);
      u_ctrl.issue(1'b1, 4'hf, 3);
      u_ctrl.issue(1'b1, 4'h1, 1);
      u_ctrl.issue(1'b0, 4'h1, 1);
      check(8'(lp_state), 8'h03);
      u_ctrl.issue(1'b0, 4'h1, 3);
      u_ctrl.issue(1'b1, 4'hf, 9);
      check(8'(lp_state), 8'h00);
      @(negedge clk);
      mr1_dll_disable = 1'b0;
      // Power-down: receivers off after the guard interval, then reset pin
      u_ctrl.issue(1'b0, 4'h7, 1);
      check(8'(status.rx_en), 8'h01);
      u_ctrl.issue(1'b0, 4'h7, 1);
      check(8'(status.rx_en), 8'h00);
      // Flavour is frozen while an operation is still running
      @(negedge clk);
      ops_busy = 1'b1;
      banks_open = 1'b1;
      u_ctrl.issue(1'b0, 4'h7, 2);
      check(8'(lp_state), 8'h02);
      @(negedge clk);
      ops_busy = 1'b0;
      u_ctrl.issue(1'b0, 4'h7, 1);
      check(8'(lp_state), 8'h01);
      u_ctrl.set_reset(1'b0, 2);
      check(8'(lp_state), 8'h00);
      check(8'(status), 8'(dsp_pkg::STAT_RST));
      u_ctrl.set_reset(1'b1, 2);
      complete_run();
   end
endmodule
